/* rtl/ssp_pkg.sv */
package ssp_pkg;

   // fifo geometry, register address width and shifter width
   localparam int unsigned FIFO_W = 16;
   localparam int unsigned FIFO_D = 8;
   localparam int unsigned ADDR_W = 3;
   localparam int unsigned SH_W   = 25;

   // register word indices; byte address is four times the index
   localparam logic [2:0] REG_CTRL0 = 3'h0;
   localparam logic [2:0] REG_CTRL1 = 3'h1;
   localparam logic [2:0] REG_DATA  = 3'h2;
   localparam logic [2:0] REG_STAT  = 3'h3;
   localparam logic [2:0] REG_PRESC = 3'h4;
   localparam logic [2:0] REG_IMASK = 3'h5;
   localparam logic [2:0] REG_RIS   = 3'h6;

   // values after reset and the smallest divisor
   localparam logic [15:0] CTRL0_RST = 16'h0007;
   localparam logic [2:0]  CTRL1_RST = 3'h0;
   localparam logic [7:0]  PRESC_RST = 8'h02;
   localparam logic [7:0]  PRESC_MIN = 8'h02;
   localparam logic [1:0]  IMASK_RST = 2'h0;

   // dss field floor and message frame sizes in bits
   localparam logic [3:0] DSS_MIN = 4'h3;
   localparam logic [4:0] MSG_LEN = 5'h08;
   localparam logic [4:0] MSG_GAP = 5'h01;

   // bit positions in status and interrupt registers
   localparam int unsigned IRQ_TXE = 0;
   localparam int unsigned IRQ_RNE = 1;
   localparam int unsigned ST_TXE  = 0;
   localparam int unsigned ST_TNF  = 1;
   localparam int unsigned ST_RNE  = 2;
   localparam int unsigned ST_RFF  = 3;
   localparam int unsigned ST_BSY  = 4;

   typedef enum logic [1:0] {FMT_SPI, FMT_TI, FMT_MSG} ssp_fmt_type;

   typedef struct packed {
      logic [7:0] serial_clock_rate;
      logic       sph;
      logic       spo;
      logic [1:0] fmt;
      logic [3:0] dss;
   } ssp_ctrl0_type;

   typedef struct packed {
      logic slave;
      logic enable;
      logic loop;
   } ssp_ctrl1_type;

   typedef struct packed {
      logic drive;
      logic oe;
   } ssp_pin_type;

endpackage

/* rtl/ssp_fifo.sv */
`timescale 1ns/100ps
`default_nettype none

module ssp_fifo
   import ssp_pkg::*;
#(
   parameter int unsigned WIDTH = FIFO_W,
   parameter int unsigned DEPTH = FIFO_D
)
(
   input  wire logic                       mclk,
   input  wire logic                       rstn,
   input  wire logic                       in_valid,
   input  wire logic [WIDTH-1:0]           in_data,
   output logic                            in_ready,
   output logic                            out_valid,
   output logic [WIDTH-1:0]                out_data,
   input  wire logic                       out_ready,
   output logic [WIDTH-1:0]                stale_data,
   output logic [$clog2(DEPTH):0]          level
);

   localparam int unsigned PW = $clog2(DEPTH);

   // pointers wrap by overflow, so only powers of two are served
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
      $error("ssp_fifo: DEPTH must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_q;
   logic [PW-1:0]    rd_q;
   logic [PW:0]      cnt_q;
   logic             push;
   logic             pop;

   // handshakes; a push against a full buffer is simply not taken
   assign in_ready   = cnt_q != (PW+1)'(DEPTH);
   assign out_valid  = cnt_q != '0;
   assign push       = in_valid & in_ready;
   assign pop        = out_valid & out_ready;
   assign out_data   = mem[rd_q];
   assign stale_data = mem[wr_q];
   assign level      = cnt_q;

   // entries are never cleared by a pop, so the slot under the write
   // pointer always holds the eighth most recent write, zero after reset
   for (genvar i = 0; i < DEPTH; i++) begin : g_ent
      always_ff @(posedge mclk) begin
         if (!rstn) begin
            mem[i] <= '0;
         end else if (push && wr_q == PW'(i)) begin
            mem[i] <= in_data;
         end
      end
   end

   // pointers and fill level
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wr_q <= wr_q + PW'(1);
         if (pop) rd_q <= rd_q + PW'(1);
         if (push && !pop) cnt_q <= cnt_q + (PW+1)'(1);
         else if (pop && !push) cnt_q <= cnt_q - (PW+1)'(1);
      end
   end

   default clocking f_cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   a_level_bound: assert property (cnt_q <= (PW+1)'(DEPTH))
      else $error("fifo level above depth");

   a_full_hold: assert property (in_valid && !in_ready && !pop |=>
      level == $past(level) && wr_q == $past(wr_q))
      else $error("write to full fifo changed it");

endmodule

`default_nettype wire

/* rtl/ssp_top.sv */
`timescale 1ns/100ps
`default_nettype none

module ssp_top
   import ssp_pkg::*;
#(
   parameter int unsigned DEPTH = FIFO_D
)
(
   input  wire logic              mclk,
   input  wire logic              rstn,
   input  wire logic [ADDR_W-1:0] avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   output logic      [31:0]       avs_readdata,
   output logic                   avs_waitrequest,
   input  wire logic              serial_clock_pin_in,
   output var ssp_pin_type        serial_clock_pin_out,
   input  wire logic              frame_select_pin_in,
   output var ssp_pin_type        frame_select_pin_out,
   input  wire logic              serial_in_pin,
   output var ssp_pin_type        serial_out_pin,
   output logic                   irq
);

   typedef enum {M_IDLE, M_LEAD, M_XFER, M_TRAIL} ssp_mst_type;

   localparam int unsigned LW = $clog2(DEPTH) + 1;

   ssp_ctrl0_type    c0_q;
   ssp_ctrl1_type    c1_q;
   logic [7:0]       presc_q;
   logic [1:0]       imask_q;
   logic             ack_q;
   logic             irq_q;
   ssp_mst_type      st_q;
   logic             lead_q;
   logic [6:0]       pre_cnt_q;
   logic [7:0]       scr_cnt_q;
   logic             tgl_q;
   logic             fss_q;
   logic [SH_W-1:0]  tx_sh_q;
   logic [15:0]      rx_sh_q;
   logic [5:0]       e_q;
   logic             push_q;
   logic [2:0]       pin_s1_q;
   logic [2:0]       pin_s2_q;
   logic             sclk_p_q;
   logic             sact_q;
   logic             sdone_q;

   // bus decode
   logic             req;
   logic             acc_wr;
   logic             acc_rd;
   logic             wr_data;
   logic             rd_data;
   logic [7:0]       presc_wr;
   logic [31:0]      rd_mux;
   logic [4:0]       stat;
   logic [1:0]       ris;

   // frame shape
   ssp_fmt_type      fmt;
   logic             is_msg;
   logic             is_ti;
   logic             master;
   logic             sph_eff;
   logic             spo_eff;
   logic [3:0]       dss_eff;
   logic [4:0]       nbits;
   logic [4:0]       total;
   logic [5:0]       last_e;
   logic [15:0]      rx_mask;

   // engine events
   logic             pre_tick;
   logic             half_tick;
   logic             ev;
   logic             cap;
   logic             cap_en;
   logic             shf;
   logic             done_ev;
   logic             rx_bit;
   logic             m_start;
   logic             s_start;
   logic             load;
   logic             sclk_edge;
   logic             sclk_fall;

   // fifo ports
   logic             tx_rdy;
   logic             tx_ov;
   logic [15:0]      tx_dat;
   logic [15:0]      tx_stale;
   logic [LW-1:0]    tx_lvl;
   logic [15:0]      tx_word;
   logic [SH_W-1:0]  tx_load;
   logic             rx_rdy;
   logic             rx_ov;
   logic [15:0]      rx_dat;
   logic [LW-1:0]    rx_lvl;

   // avalon slave: every access answers in its second cycle
   assign req             = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_q;
   assign acc_wr          = avs_write & ack_q;
   assign acc_rd          = avs_read & ack_q;
   assign wr_data         = acc_wr && avs_address == REG_DATA;
   assign rd_data         = acc_rd && avs_address == REG_DATA;

   // odd or too small divisors are forced even and at least two
   assign presc_wr = (avs_writedata[7:0] < PRESC_MIN) ? PRESC_MIN
                   : {avs_writedata[7:1], 1'b0};

   // status and raw interrupt view
   assign stat[ST_TXE] = ~tx_ov;
   assign stat[ST_TNF] = tx_rdy;
   assign stat[ST_RNE] = rx_ov;
   assign stat[ST_RFF] = ~rx_rdy;
   assign stat[ST_BSY] = st_q != M_IDLE || sact_q || tx_ov;
   assign ris[IRQ_TXE] = ~tx_ov;
   assign ris[IRQ_RNE] = rx_ov;

   // read selection; unmapped words read as zero
   assign rd_mux = (avs_address == REG_CTRL0) ? {16'h0000, c0_q}
                 : (avs_address == REG_CTRL1) ? {29'h00000000, c1_q}
                 : (avs_address == REG_DATA)  ? {16'h0000, rx_dat}
                 : (avs_address == REG_STAT)  ? {27'h0000000, stat}
                 : (avs_address == REG_PRESC) ? {24'h000000, presc_q}
                 : (avs_address == REG_IMASK) ? {30'h00000000, imask_q}
                 : (avs_address == REG_RIS)   ? {30'h00000000, ris}
                 : 32'h00000000;

   // bus handshake and read capture in the first cycle of an access
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         ack_q        <= 1'b0;
         avs_readdata <= 32'h00000000;
      end else begin
         ack_q <= req & ~ack_q;
         if (req && !ack_q) avs_readdata <= rd_mux;
      end
   end

   // configuration registers, written at the accepting edge
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         c0_q    <= CTRL0_RST;
         c1_q    <= CTRL1_RST;
         presc_q <= PRESC_RST;
         imask_q <= IMASK_RST;
      end else if (acc_wr) begin
         case (avs_address)
            REG_CTRL0: c0_q <= avs_writedata[15:0];
            REG_CTRL1: c1_q <= avs_writedata[2:0];
            REG_PRESC: presc_q <= presc_wr;
            REG_IMASK: imask_q <= avs_writedata[1:0];
            default: ;
         endcase
      end
   end

   // single request line from every masked source
   always_ff @(posedge mclk) begin
      if (!rstn) irq_q <= 1'b0;
      else irq_q <= |(ris & imask_q);
   end
   assign irq = irq_q;

   // frame shape; sizes below four bits are raised to four
   assign fmt     = ssp_fmt_type'(c0_q.fmt);
   assign is_msg  = fmt == FMT_MSG;
   assign is_ti   = fmt == FMT_TI;
   assign master  = ~c1_q.slave;
   assign sph_eff = is_ti | (fmt == FMT_SPI & c0_q.sph);
   assign spo_eff = fmt == FMT_SPI & c0_q.spo;
   assign dss_eff = (c0_q.dss < DSS_MIN) ? DSS_MIN : c0_q.dss;
   assign nbits   = {1'b0, dss_eff} + 5'h01;
   assign total   = is_msg ? MSG_LEN + MSG_GAP + nbits : nbits;
   assign last_e  = {total, 1'b0} - 6'h01;
   assign rx_mask = 16'hFFFF >> (5'h10 - nbits);

   // two-stage divider: half period is presc/2 times (1 + rate) cycles
   assign pre_tick  = st_q != M_IDLE && pre_cnt_q == presc_q[7:1] - 7'h01;
   assign half_tick = pre_tick && scr_cnt_q == c0_q.serial_clock_rate;

   always_ff @(posedge mclk) begin
      if (!rstn || st_q == M_IDLE || pre_tick) pre_cnt_q <= 7'h00;
      else pre_cnt_q <= pre_cnt_q + 7'h01;
   end

   always_ff @(posedge mclk) begin
      if (!rstn || st_q == M_IDLE || half_tick) scr_cnt_q <= 8'h00;
      else if (pre_tick) scr_cnt_q <= scr_cnt_q + 8'h01;
   end

   // pin synchronisers: sclk, frame select, serial in
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         pin_s1_q <= 3'h0;
         pin_s2_q <= 3'h0;
         sclk_p_q <= 1'b0;
      end else begin
         pin_s1_q <= {serial_in_pin, frame_select_pin_in, serial_clock_pin_in};
         pin_s2_q <= pin_s1_q;
         sclk_p_q <= pin_s2_q[0];
      end
   end

   // slave sees edges three cycles late, hence the 12x clock ratio limit
   assign sclk_edge = pin_s2_q[0] ^ sclk_p_q;
   assign sclk_fall = sclk_p_q & ~pin_s2_q[0];

   // starts: master when data waits, slave whenever the master frames
   assign m_start = master && c1_q.enable && st_q == M_IDLE && tx_ov;
   assign s_start = c1_q.slave && c1_q.enable && !sact_q
                 && (is_ti ? (sclk_fall && pin_s2_q[1])
                           : (!pin_s2_q[1] && (!sdone_q || sph_eff)));
   assign load    = m_start | s_start;

   // an empty buffer in slave mode replays the oldest stored write
   assign tx_word = tx_ov ? tx_dat : tx_stale;
   assign tx_load = is_msg ? {tx_word[7:0], 17'h00000}
                  : ({tx_word, 9'h000} << (5'h10 - nbits));

   // shared bit engine: e_q counts clock edges inside the frame
   assign ev      = master ? (st_q == M_XFER && half_tick) : (sact_q && sclk_edge);
   assign cap     = ev && (e_q[0] == sph_eff);
   assign shf     = ev && !cap && e_q != 6'h00;
   assign cap_en  = !is_msg || e_q[5:1] >= MSG_LEN + MSG_GAP;
   assign done_ev = ev && e_q == last_e;
   assign rx_bit  = c1_q.loop ? tx_sh_q[SH_W-1] : pin_s2_q[2];

   // master sequencer: lead period, data edges, trailing half period
   always_ff @(posedge mclk) begin
      if (!rstn || !c1_q.enable || !master) begin
         st_q   <= M_IDLE;
         lead_q <= 1'b0;
      end else begin
         case (st_q)
            M_IDLE: begin
               lead_q <= 1'b0;
               if (m_start) st_q <= M_LEAD;
            end
            M_LEAD: begin
               if (half_tick) begin
                  lead_q <= 1'b1;
                  if (lead_q) st_q <= M_XFER;
               end
            end
            M_XFER: begin
               if (done_ev) st_q <= M_TRAIL;
            end
            M_TRAIL: begin
               if (half_tick) st_q <= M_IDLE;
            end
            default: st_q <= M_IDLE;
         endcase
      end
   end

   // clock level rests at its idle value outside the data phase
   always_ff @(posedge mclk) begin
      if (!rstn) tgl_q <= 1'b0;
      else if (st_q != M_XFER) tgl_q <= spo_eff;
      else if (ev) tgl_q <= ~tgl_q;
   end

   // frame select: pulse before the frame, or held low across it
   always_ff @(posedge mclk) begin
      if (!rstn) fss_q <= 1'b1;
      else if (is_ti) fss_q <= st_q == M_LEAD;
      else fss_q <= !(st_q == M_LEAD || st_q == M_XFER);
   end

   // slave frame tracking; a raised select aborts the four-wire frame
   always_ff @(posedge mclk) begin
      if (!rstn || !c1_q.enable) begin
         sact_q  <= 1'b0;
         sdone_q <= 1'b0;
      end else begin
         if (s_start) sact_q <= 1'b1;
         else if (done_ev || (!is_ti && pin_s2_q[1])) sact_q <= 1'b0;
         if (pin_s2_q[1]) sdone_q <= 1'b0;
         else if (done_ev) sdone_q <= 1'b1;
      end
   end

   // transmit shifter, msb first
   always_ff @(posedge mclk) begin
      if (!rstn) tx_sh_q <= '0;
      else if (load) tx_sh_q <= tx_load;
      else if (shf) tx_sh_q <= {tx_sh_q[SH_W-2:0], 1'b0};
   end

   // receive shifter and edge counter
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rx_sh_q <= 16'h0000;
         e_q     <= 6'h00;
         push_q  <= 1'b0;
      end else begin
         if (cap && cap_en) rx_sh_q <= {rx_sh_q[14:0], rx_bit};
         if (load) e_q <= 6'h00;
         else if (ev) e_q <= e_q + 6'h01;
         push_q <= done_ev; // last capture lands first, then the load
      end
   end

   // pins; the frame-pulse format floats data between frames
   assign serial_clock_pin_out.drive = tgl_q;
   assign serial_clock_pin_out.oe    = c1_q.enable & master;
   assign frame_select_pin_out.drive = fss_q;
   assign frame_select_pin_out.oe    = c1_q.enable & master;
   assign serial_out_pin.drive       = tx_sh_q[SH_W-1];
   assign serial_out_pin.oe          = master ? c1_q.enable & (!is_ti | st_q != M_IDLE)
                                              : sact_q;

   // transmit buffer; a write to a full buffer is dropped there
   ssp_fifo #(.WIDTH(FIFO_W), .DEPTH(DEPTH)) u_txf (
      .mclk       (mclk),
      .rstn       (rstn),
      .in_valid   (wr_data),
      .in_data    (avs_writedata[15:0]),
      .in_ready   (tx_rdy),
      .out_valid  (tx_ov),
      .out_data   (tx_dat),
      .out_ready  (load),
      .stale_data (tx_stale),
      .level      (tx_lvl)
   );

   // receive buffer; a word arriving while full is lost
   ssp_fifo #(.WIDTH(FIFO_W), .DEPTH(DEPTH)) u_rxf (
      .mclk       (mclk),
      .rstn       (rstn),
      .in_valid   (push_q),
      .in_data    (rx_sh_q & rx_mask),
      .in_ready   (rx_rdy),
      .out_valid  (rx_ov),
      .out_data   (rx_dat),
      .out_ready  (rd_data),
      .stale_data (),
      .level      (rx_lvl)
   );

   default clocking t_cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   sequence s_lead_hold;
      (st_q == M_LEAD) [*2];
   endsequence

   a_master_lead: assert property (m_start |=> s_lead_hold)
      else $error("master lead period shorter than one clock");

   a_sclk_idle: assert property (master && st_q == M_IDLE && $stable(c0_q)
      && $past(st_q) == M_IDLE |-> serial_clock_pin_out.drive == spo_eff)
      else $error("serial clock not at idle level");

   a_sclk_on_tick: assert property (master && $past(st_q) == M_XFER
      && $changed(tgl_q) |-> $past(half_tick))
      else $error("serial clock moved off a divider tick");

   a_write_push: assert property (wr_data && tx_rdy && !load |=>
      tx_lvl == $past(tx_lvl) + LW'(1))
      else $error("data write did not enter transmit buffer");

   a_frame_len: assert property (push_q |-> $past(e_q) == last_e)
      else $error("frame pushed at wrong bit count");

   a_loop_return: assert property (c1_q.loop && cap && cap_en |=>
      rx_sh_q[0] == $past(tx_sh_q[SH_W-1]))
      else $error("loopback bit not returned");

   a_stale_load: assert property (s_start && !tx_ov |=>
      tx_sh_q == $past(tx_load) && $past(tx_word) == $past(tx_stale))
      else $error("empty slave transfer did not replay old entry");

   a_irq_txe: assert property (imask_q[IRQ_TXE] && !tx_ov |=> irq)
      else $error("empty transmit buffer raised no request");

   a_rx_pop: assert property (rd_data && rx_ov && !push_q |=>
      rx_lvl == $past(rx_lvl) - LW'(1))
      else $error("data read did not remove received word");

endmodule

`default_nettype wire

/* bench/ssp_peer.sv */
`timescale 1ns/100ps
`default_nettype none

// far-side device: a mode 0 slave while the port masters, a master otherwise
module ssp_peer (
   input  wire logic sclk,
   input  wire logic fss,
   input  wire logic sdi,
   output var logic  sdo,
   output var logic  sclk_m,
   output var logic  fss_m
);
   logic [15:0] reply;
   logic [15:0] tx_q;
   logic [15:0] rx_q;
   logic        role_m;
   int          i;

   initial begin
      {sdo, sclk_m, fss_m, role_m} = 4'h2;
      {reply, tx_q, rx_q} = 48'h0;
   end

   // slave role: msb first, capture on rising, shift on falling
   always @(negedge fss) if (!role_m) begin
      tx_q = reply;
      sdo = reply[15];
   end
   always @(posedge sclk) if (!role_m && !fss) rx_q = {rx_q[14:0], sdi};
   always @(negedge sclk) if (!role_m && !fss) begin
      tx_q = tx_q << 1;
      sdo = tx_q[15];
   end
   // a deselected line must not keep its last level
   always @(posedge fss) if (!role_m) sdo = ~sdo;

   // master role: half period of 8 system clocks, slower than a twelfth
   task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
      #1; // keep pin changes off the system clock edge
      role_m = 1'b1;
      fss_m = 1'b0;
      sdo = w[n-1];
      #40;
      for (i = n - 1; i >= 0; i--) begin
         sclk_m = 1'b1;
         r = {r[14:0], sdi};
         #40;
         sclk_m = 1'b0;
         if (i > 0) sdo = w[i-1];
         #40;
      end
      fss_m = 1'b1;
      sdo = ~sdo;
      #200;
      role_m = 1'b0;
   endtask
endmodule

`default_nettype wire

/* bench/tb_ssp_top.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_ssp_top
   import ssp_pkg::*;
;
   logic              mclk;
   logic              rstn;
   logic              avs_read;
   logic              avs_write;
   logic [ADDR_W-1:0] avs_address;
   logic [31:0]       avs_writedata;
   logic [31:0]       avs_readdata;
   logic              avs_waitrequest;
   logic              irq;
   logic              peer_sdo;
   logic              peer_sclk;
   logic              peer_fss;
   ssp_pin_type       sclk_o;
   ssp_pin_type       fss_o;
   ssp_pin_type       sout_o;
   int                err_count;
   int                checks;
   int                i;
   int                n;
   int                k;
   int                t[2];
   logic              prev;
   logic [31:0]       q;
   logic [15:0]       r;
   logic [2:0]        ra[6] = '{REG_CTRL0, REG_CTRL1, REG_PRESC, REG_IMASK, REG_STAT, 3'h7};
   logic [31:0]       re[6] = '{32'h7, 32'h0, 32'h2, 32'h0, 32'h3, 32'h0};
   logic [31:0]       pw[3] = '{32'h0, 32'hFF, 32'h5};
   logic [31:0]       pe[3] = '{32'h2, 32'hFE, 32'h4};

   // pin levels: whoever enables its driver owns the wire
   wire sclk_w = sclk_o.oe ? sclk_o.drive : peer_sclk;
   wire fss_w  = fss_o.oe ? fss_o.drive : peer_fss;
   wire sout_w = sout_o.oe ? sout_o.drive : ~sout_o.drive; // released line shows the inverse

   initial mclk = 1'b0;
   always #2.5 mclk = ~mclk;

   ssp_top u_dut (
      .mclk                 (mclk),
      .rstn                 (rstn),
      .avs_address          (avs_address),
      .avs_read             (avs_read),
      .avs_write            (avs_write),
      .avs_writedata        (avs_writedata),
      .avs_readdata         (avs_readdata),
      .avs_waitrequest      (avs_waitrequest),
      .serial_clock_pin_in  (sclk_w),
      .serial_clock_pin_out (sclk_o),
      .frame_select_pin_in  (fss_w),
      .frame_select_pin_out (fss_o),
      .serial_in_pin        (peer_sdo),
      .serial_out_pin       (sout_o),
      .irq                  (irq)
   );

   ssp_peer u_peer (
      .sclk   (sclk_w),
      .fss    (fss_w),
      .sdi    (sout_w),
      .sdo    (peer_sdo),
      .sclk_m (peer_sclk),
      .fss_m  (peer_fss)
   );

   task automatic wrap_up;
      if (err_count == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one bus access; the request is held until waitrequest is seen low
   task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
      int c;
      c = 0;
      @(posedge mclk);
      avs_write <= w;
      avs_read <= ~w;
      avs_address <= a;
      avs_writedata <= d;
      do begin
         @(posedge mclk);
         c++;
      end while (avs_waitrequest !== 1'b0 && c < 100);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (c >= 100) begin
         err_count++;
         wrap_up();
      end
   endtask

   // poll status until nothing waits and the shifter is quiet
   task automatic wait_idle;
      int c;
      for (c = 0; c < 3000; c++) begin
         bus(1'b0, REG_STAT, 32'h0);
         if (q[ST_BSY] === 1'b0 && q[ST_TXE] === 1'b1) break;
      end
      if (c >= 3000) begin
         err_count++;
         wrap_up();
      end
   endtask

   initial begin
      {rstn, avs_read, avs_write, avs_address, avs_writedata} = '0;
      err_count = 0;
      checks = 0;
      repeat (10) @(posedge mclk);
      rstn <= 1'b1;
      // reset values, unmapped index reads zero
      foreach (ra[j]) begin
         bus(1'b0, ra[j], 32'h0);
         chk(q, re[j]);
      end
      // transmit-empty source unmasked: request follows a cycle later
      bus(1'b1, REG_IMASK, 32'h1);
      repeat (2) @(posedge mclk);
      chk(irq, 32'h1);
      bus(1'b1, REG_IMASK, 32'h0);
      foreach (pw[j]) begin
         bus(1'b1, REG_PRESC, pw[j]);
         bus(1'b0, REG_PRESC, 32'h0);
         chk(q, pe[j]);
      end
      // slave, 16-bit frames; nothing written yet, so zero goes out
      bus(1'b1, REG_CTRL0, 32'h000F);
      bus(1'b1, REG_CTRL1, 32'h6);
      u_peer.xfer(16'h1000, 16, r);
      chk(r, 32'h0);
      for (i = 0; i < 8; i++) bus(1'b1, REG_DATA, 32'h8E00 + i);
      chk({sclk_o.oe, fss_o.oe, sout_o.oe}, 32'h0);
      for (i = 0; i < 8; i++) begin
         u_peer.xfer(16'h1001 + i, 16, r);
         chk(r, 32'h8E00 + i);
      end
      u_peer.xfer(16'h1009, 16, r);
      chk(r, 32'h8E00);
      // only the first eight arrivals fit; later ones are dropped
      for (i = 0; i < 8; i++) begin
         bus(1'b0, REG_DATA, 32'h0);
         chk(q, 32'h1000 + i);
      end
      // fill while stopped; the ninth write must vanish, queued words count as busy
      bus(1'b1, REG_CTRL1, 32'h0);
      for (i = 0; i < 9; i++) bus(1'b1, REG_DATA, 32'h5A00 + i);
      bus(1'b0, REG_STAT, 32'h0);
      chk(q, 32'h10);
      bus(1'b1, REG_CTRL1, 32'h3);
      wait_idle();
      for (i = 0; i < 8; i++) begin
         bus(1'b0, REG_DATA, 32'h0);
         chk(q, 32'h5A00 + i);
      end
      bus(1'b0, REG_STAT, 32'h0);
      chk(q, 32'h3);
      // loopback in frame-pulse, control-message and mode 3 framing
      bus(1'b1, REG_CTRL0, 32'h0017);
      bus(1'b1, REG_DATA, 32'h00C3);
      wait_idle();
      bus(1'b0, REG_DATA, 32'h0);
      chk(q, 32'hC3);
      // message format returns only what follows the byte, here zeros
      bus(1'b1, REG_CTRL0, 32'h0027);
      bus(1'b1, REG_DATA, 32'h00A5);
      wait_idle();
      bus(1'b0, REG_DATA, 32'h0);
      chk(q, 32'h0);
      bus(1'b1, REG_CTRL0, 32'h00C7);
      bus(1'b1, REG_DATA, 32'h0069);
      wait_idle();
      bus(1'b0, REG_DATA, 32'h0);
      chk(q, 32'h69);
      chk(sclk_o.drive, 32'h1);
      // master to the peer, 8-bit frames, half period of three clocks
      bus(1'b1, REG_PRESC, 32'h2);
      bus(1'b1, REG_CTRL0, 32'h0207);
      bus(1'b1, REG_CTRL1, 32'h2);
      u_peer.reply = 16'h9600;
      bus(1'b1, REG_DATA, 32'hA55A);
      wait_idle();
      bus(1'b0, REG_DATA, 32'h0);
      chk(q, 32'h96);
      chk(u_peer.rx_q[7:0], 32'h5A);
      chk(sclk_o.drive, 32'h0);
      chk({sclk_o.oe, fss_o.oe, fss_o.drive}, 32'h7);
      // prescale 4 and rate field 1 give eight clocks per serial period
      bus(1'b1, REG_PRESC, 32'h4);
      bus(1'b1, REG_CTRL0, 32'h0107);
      bus(1'b1, REG_DATA, 32'h3C);
      k = 0;
      prev = 1'b0;
      t = '{0, 0};
      for (n = 0; n < 600 && k < 2; n++) begin
         @(posedge mclk);
         if (sclk_o.drive && !prev) begin
            t[k] = n;
            k++;
         end
         prev = sclk_o.drive;
      end
      chk(t[1] - t[0], 32'h8);
      wait_idle();
      wrap_up();
   end
endmodule

`default_nettype wire
